// ==== dv/tmr2_pin_src.sv ====
// partner model: source of trigger and count pin falling edges
`default_nettype none
module tmr2_pin_src (
  input  wire logic clk_sys_i,
  input  wire logic trig_req_i,
  input  wire logic cnt_req_i,
  output logic      trig_pin_o,
  output logic      count_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // cycles left in the low phase of each pin
  logic [1:0] trig_lo_q = 2'h0;
  logic [1:0] cnt_lo_q  = 2'h0;
  // a request starts a three-cycle low phase
  // three cycles low, so a sampler at core rate sees 1 then 0 reliably
  always_ff @(posedge clk_sys_i) begin
    trig_lo_q <= trig_req_i ? 2'h3 : (trig_lo_q != 2'h0 ? trig_lo_q - 2'h1 : 2'h0);
    cnt_lo_q  <= cnt_req_i ? 2'h3 : (cnt_lo_q != 2'h0 ? cnt_lo_q - 2'h1 : 2'h0);
  end
  // pins idle high, like a port pin with pull-up
  assign trig_pin_o  = (trig_lo_q == 2'h0);
  assign count_pin_o = (cnt_lo_q == 2'h0);
endmodule : tmr2_pin_src
`default_nettype wire

// ==== dv/tmr2_top_tb.sv ====
// testbench: register, mode, pin and baud scenarios for timer2
`default_nettype none
module tmr2_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // table row: write, then read back
  typedef struct packed {
    logic [3:0] wa;
    logic [7:0] wd;
    logic [3:0] ra;
    logic [7:0] ex;
  } tmr2_row_t;
  logic       clk_sys = 1'b0;
  logic       nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       trig_req = 1'b0;
  logic       cnt_req = 1'b0;
  logic       oth_ovf = 1'b0;
  logic       oth_en = 1'b0;
  logic [7:0] rdata, d, e, drx, dtx;
  logic [7:0] rx_n = 8'h00;
  logic [7:0] tx_n = 8'h00;
  logic       trig_pin, count_pin, rx_tick, tx_tick, irq;
  int         n_errors = 0;
  int         num_checks = 0;
  tmr2_row_t  rows [9] = '{
    {4'h3, 8'h5A, 4'h3, 8'h5A}, {4'h4, 8'hA5, 4'h4, 8'hA5}, {4'h1, 8'h34, 4'h1, 8'h34},
    {4'h2, 8'h12, 4'h2, 8'h12}, {4'h7, 8'h03, 4'h7, 8'h03}, {4'h8, 8'hFF, 4'h8, 8'h00},
    {4'h5, 8'hFF, 4'h5, 8'h00}, {4'h0, 8'h09, 4'h0, 8'h09}, {4'h0, 8'h00, 4'h0, 8'h00}};
  // clock: 4 ns period
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  // other timer overflow, a pulse every second cycle while enabled
  always @(posedge clk_sys) begin
    oth_ovf <= oth_en & ~oth_ovf;
    if (rx_tick === 1'b1) rx_n <= rx_n + 8'h01;
    if (tx_tick === 1'b1) tx_n <= tx_n + 8'h01;
  end
  // short tick parameter keeps the run brief
  tmr2_top #(.OSC_DIV(2)) tmr2_top_i (
    .clk_sys_i(clk_sys), .nrst_i(nrst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .trig_pin_i(trig_pin),
    .count_pin_i(count_pin), .other_timer_ovf_i(oth_ovf), .rx_baud_tick_o(rx_tick),
    .tx_baud_tick_o(tx_tick), .irq_o(irq));
  tmr2_pin_src tmr2_pin_src_i (
    .clk_sys_i(clk_sys), .trig_req_i(trig_req), .cnt_req_i(cnt_req),
    .trig_pin_o(trig_pin), .count_pin_o(count_pin));
  // counts and verdict, then end of run
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  // one compare for every byte-sized result
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  // one-cycle read strobe; data stands in the following cycle only
  task automatic rdq(input logic [3:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask : rdq
  // read, then compare against the expected byte
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    rdq(a);
    chk(d, exp);
  endtask : rdc
  // ask the partner for one falling edge, then let it settle
  task automatic pin(input logic t);
    @(posedge clk_sys);
    if (t) trig_req <= 1'b1;
    else cnt_req <= 1'b1;
    @(posedge clk_sys);
    trig_req <= 1'b0;
    cnt_req <= 1'b0;
    repeat (10) @(posedge clk_sys);
  endtask : pin
  // bounded wait for the interrupt line
  task automatic wait_irq();
    for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge clk_sys);
    if (irq !== 1'b1) begin
      n_errors++;
      conclude();
    end
  endtask : wait_irq
  // baud tick counts over a fixed window
  task automatic win();
    logic [7:0] a;
    logic [7:0] b;
    a = rx_n;
    b = tx_n;
    repeat (80) @(posedge clk_sys);
    drx = rx_n - a;
    dtx = tx_n - b;
  endtask : win
  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    foreach (rows[i]) rdc(rows[i].ra, 8'h00); // reset values first
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      rdc(rows[i].ra, rows[i].ex);
    end
    // auto-reload on rollover, interrupt, stop
    wr(4'h3, 8'h00);
    wr(4'h4, 8'hAB);
    wr(4'h1, 8'hFE);
    wr(4'h2, 8'hFF);
    wr(4'h0, 8'h04);
    wait_irq();
    rdc(4'h0, 8'h84);
    wr(4'h0, 8'h80);
    rdc(4'h0, 8'h80);
    rdc(4'h2, 8'hAB);
    chk({7'h00, irq}, 8'h01);
    rdq(4'h1);
    e = d;
    repeat (20) @(posedge clk_sys);
    rdc(4'h1, e);
    wr(4'h6, 8'h01);
    rdc(4'h0, 8'h00);
    chk({7'h00, irq}, 8'h00);
    // count pin as source: internal ticks must not count
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h00);
    wr(4'h0, 8'h06);
    repeat (3) pin(1'b0);
    wr(4'h0, 8'h02);
    rdc(4'h1, 8'h03);
    // trigger ignored without enable, reloads with it
    wr(4'h1, 8'h34);
    wr(4'h2, 8'h12);
    wr(4'h0, 8'h00);
    pin(1'b1);
    rdc(4'h2, 8'h12);
    rdc(4'h0, 8'h00);
    wr(4'h0, 8'h0E);
    pin(1'b1);
    rdc(4'h2, 8'hAB);
    rdc(4'h0, 8'h4E);
    chk({7'h00, irq}, 8'h01);
    wr(4'h0, 8'h08);
    rdc(4'h0, 8'h08);
    // capture copies the count into the reload registers
    wr(4'h1, 8'h34);
    wr(4'h2, 8'h12);
    wr(4'h0, 8'h0F);
    pin(1'b1);
    rdc(4'h3, 8'h34);
    rdc(4'h4, 8'h12);
    rdc(4'h0, 8'h4F);
    rdc(4'h2, 8'h12);
    // baud mode: capture select ignored, no flags, ticks out
    wr(4'h3, 8'hF8);
    wr(4'h4, 8'hFF);
    wr(4'h1, 8'hF8);
    wr(4'h2, 8'hFF);
    wr(4'h0, 8'h3D);
    win();
    chk({7'h00, drx != 8'h00}, 8'h01);
    chk({7'h00, dtx != 8'h00}, 8'h01);
    pin(1'b1);
    wr(4'h0, 8'h39);
    rdc(4'h0, 8'h39);
    rdc(4'h2, 8'hFF);
    // receive select only: transmit follows the other timer
    @(posedge clk_sys);
    oth_en <= 1'b1;
    wr(4'h0, 8'h24);
    win();
    chk({7'h00, drx != 8'h00}, 8'h01);
    chk({7'h00, dtx != 8'h00}, 8'h01);
    // transmit select only: receive follows the other timer
    wr(4'h0, 8'h14);
    win();
    chk({7'h00, drx != 8'h00}, 8'h01);
    chk({7'h00, dtx != 8'h00}, 8'h01);
    wr(4'h0, 8'h24);
    @(posedge clk_sys);
    oth_en <= 1'b0;
    repeat (4) @(posedge clk_sys);
    win();
    chk(dtx, 8'h00);
    chk({7'h00, drx != 8'h00}, 8'h01);
    // second reset in mid-run
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    rdc(4'h0, 8'h00);
    rdc(4'h4, 8'h00);
    chk({7'h00, irq}, 8'h00);
    conclude();
  end
endmodule : tmr2_top_tb
`default_nettype wire

// ==== logic/tmr2_edge_det.sv ====
// module: two-flop synchroniser and falling-edge detect for the two pins
`default_nettype none
module tmr2_edge_det (
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  input  wire logic       trig_pin_i,
  input  wire logic       count_pin_i,
  tmr2_edge_if.det        edge_o
);
  logic [1:0] sync1_q; // first stage, read only by second
  logic [1:0] sync2_q; // second stage
  logic [1:0] prev_q;  // previous synchronised sample

  // synchronise and keep one older sample
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      sync1_q <= 2'h3;
      sync2_q <= 2'h3;
      prev_q  <= 2'h3;
    end else begin
      sync1_q <= {count_pin_i, trig_pin_i};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // a 1 then a 0 in consecutive samples is a falling edge
  assign edge_o.trig_fall = prev_q[0] & ~sync2_q[0];
  assign edge_o.cnt_fall  = prev_q[1] & ~sync2_q[1];

  chk_fall_seen: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    edge_o.trig_fall |-> $past(sync2_q[0]) && !sync2_q[0])
    else $error("trigger fall without 1 then 0");
endmodule : tmr2_edge_det
`default_nettype wire

// ==== logic/tmr2_top.sv ====
// module: 16-bit timer2 with capture, auto-reload and baud generator modes
`default_nettype none
// What this block does
// - reload mode rollover sets overflow, reloads count
// - reload mode trigger fall reloads, sets external
// - either clock select forces baud mode
// - overflow flag sticky, never set in baud
// - trigger event with enable sets external flag
// - external flag requests interrupt like overflow
// - receive select routes overflow to rx clock
// - transmit select routes overflow to tx clock
// - trigger events only when enabled, not baud
// - run bit starts and stops counting
// - source: osc/12 ticks or count-pin falls
// - capsel picks capture or reload on trigger
// - baud mode forces reload on overflow
// - capture copies count into capture registers
// - capture without enable: plain timer, overflow
module tmr2_top #(
  parameter int OSC_DIV = tmr2_pkg::OSC_DIV // oscillator periods per tick
) (
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       trig_pin_i,
  input  wire logic       count_pin_i,
  input  wire logic       other_timer_ovf_i,
  output logic            rx_baud_tick_o,
  output logic            tx_baud_tick_o,
  output logic            irq_o
);
  // refuse prescaler values that the 8-bit divider cannot serve
  if (OSC_DIV < 2 || OSC_DIV > 255) begin : g_bad_div
    $error("OSC_DIV out of range");
  end

  localparam int IRQ_W_L = tmr2_pkg::IRQ_W; // status / enable width
  tmr2_edge_if edges ();                 // pin event bundle
  logic [7:0]  ctrl_q;                   // control register
  logic [15:0] count_q;                  // running count
  logic [15:0] cap_q;                    // reload / capture registers
  logic [7:0]  div_q;                    // oscillator prescaler
  logic [IRQ_W_L-1:0] irq_en_q;          // interrupt enables
  logic [7:0]  rdata_q;                  // registered read data
  logic        rx_tick_q;                // rx baud pulse
  logic        tx_tick_q;                // tx baud pulse

  tmr2_edge_det tmr2_edge_det_i (
    .clk_sys_i   (clk_sys_i),
    .nrst_i      (nrst_i),
    .trig_pin_i  (trig_pin_i),
    .count_pin_i (count_pin_i),
    .edge_o      (edges)
  );

  // decoded control fields
  logic baud, exen, run, src, capsel, tick, rollover, trig_evt;
  tmr2_pkg::tmr2_mode_t mode;
  always_comb begin
    baud   = ctrl_q[tmr2_pkg::BIT_RCLK] | ctrl_q[tmr2_pkg::BIT_TX_CLOCK_SELECT];
    exen   = ctrl_q[tmr2_pkg::BIT_EXEN];
    run    = ctrl_q[tmr2_pkg::BIT_RUN];
    src    = ctrl_q[tmr2_pkg::BIT_SRC];
    capsel = ctrl_q[tmr2_pkg::BIT_CAPSEL];
    if (!run)        mode = tmr2_pkg::TMR2_MODE_OFF;
    else if (baud)   mode = tmr2_pkg::TMR2_MODE_BAUD;
    else if (capsel) mode = tmr2_pkg::TMR2_MODE_CAPTURE;
    else             mode = tmr2_pkg::TMR2_MODE_RELOAD;
  end

  // count source: prescaled oscillator or count-pin falls
  assign tick = run & (src ? edges.cnt_fall
                           : (div_q == 8'(OSC_DIV - 1)));
  assign rollover = tick & (count_q == 16'hffff);
  // trigger events ignored without enable or while clocking serial port
  assign trig_evt = edges.trig_fall & exen & ~baud;

  // prescaler, free running so stop/start keeps phase short
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      div_q <= 8'h00;
    end else if (div_q == 8'(OSC_DIV - 1)) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // write strobes
  logic wr_ctrl, wr_cl, wr_ch, wr_rl, wr_rh, wr_clr, wr_en;
  assign wr_ctrl = reg_wr_i & (reg_addr_i == tmr2_pkg::ADDR_CONTROL);
  assign wr_cl   = reg_wr_i & (reg_addr_i == tmr2_pkg::ADDR_COUNT_LOW);
  assign wr_ch   = reg_wr_i & (reg_addr_i == tmr2_pkg::ADDR_COUNT_HIGH);
  assign wr_rl   = reg_wr_i & (reg_addr_i == tmr2_pkg::ADDR_RELOAD_LOW);
  assign wr_rh   = reg_wr_i & (reg_addr_i == tmr2_pkg::ADDR_RELOAD_HIGH);
  assign wr_clr  = reg_wr_i & (reg_addr_i == tmr2_pkg::ADDR_IRQ_CLEAR);
  assign wr_en   = reg_wr_i & (reg_addr_i == tmr2_pkg::ADDR_IRQ_ENABLE);

  // flag set conditions
  logic set_ovf, set_exf, reload, capture;
  always_comb begin
    set_ovf = 1'b0;
    set_exf = 1'b0;
    reload  = 1'b0;
    capture = 1'b0;
    case (mode)
      tmr2_pkg::TMR2_MODE_RELOAD: begin
        set_ovf = rollover;
        reload  = rollover | trig_evt;
        set_exf = trig_evt;
      end
      tmr2_pkg::TMR2_MODE_CAPTURE: begin
        set_ovf = rollover;
        capture = trig_evt;
        set_exf = trig_evt;
      end
      tmr2_pkg::TMR2_MODE_BAUD: begin
        reload  = rollover;  // no overflow flag here
      end
      default: begin
        // stopped: a trigger edge still captures or reloads when enabled
        reload  = trig_evt & ~capsel;
        capture = trig_evt & capsel;
        set_exf = trig_evt;
      end
    endcase
  end

  // control register; hardware set wins over software write
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      ctrl_q <= tmr2_pkg::CONTROL_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= reg_wdata_i;
      else if (wr_clr) begin
        // clear register also clears the matching flags
        if (reg_wdata_i[tmr2_pkg::IRQ_OVF]) ctrl_q[tmr2_pkg::BIT_OVF] <= 1'b0;
        if (reg_wdata_i[tmr2_pkg::IRQ_EXF]) ctrl_q[tmr2_pkg::BIT_EXF] <= 1'b0;
      end
      if (set_ovf) ctrl_q[tmr2_pkg::BIT_OVF] <= 1'b1;
      if (set_exf) ctrl_q[tmr2_pkg::BIT_EXF] <= 1'b1;
    end
  end

  // count register: reload beats tick, software write beats both
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      count_q <= tmr2_pkg::COUNT_RST;
    end else if (wr_cl) begin
      count_q[7:0] <= reg_wdata_i;
    end else if (wr_ch) begin
      count_q[15:8] <= reg_wdata_i;
    end else if (reload) begin
      count_q <= cap_q;
    end else if (tick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // reload / capture registers; capture overrides software
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      cap_q <= tmr2_pkg::RELOAD_RST;
    end else if (capture) begin
      cap_q <= count_q;
    end else if (wr_rl) begin
      cap_q[7:0] <= reg_wdata_i;
    end else if (wr_rh) begin
      cap_q[15:8] <= reg_wdata_i;
    end
  end

  // baud pulses: this timer's overflow or the other timer's
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      rx_tick_q <= 1'b0;
      tx_tick_q <= 1'b0;
    end else begin
      rx_tick_q <= ctrl_q[tmr2_pkg::BIT_RCLK] ? (mode == tmr2_pkg::TMR2_MODE_BAUD) & rollover
                                             : other_timer_ovf_i;
      tx_tick_q <= ctrl_q[tmr2_pkg::BIT_TX_CLOCK_SELECT] ? (mode == tmr2_pkg::TMR2_MODE_BAUD) & rollover
                                             : other_timer_ovf_i;
    end
  end
  assign rx_baud_tick_o = rx_tick_q;
  assign tx_baud_tick_o = tx_tick_q;

  // interrupt enables
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      irq_en_q <= '0;
    end else if (wr_en) begin
      irq_en_q <= reg_wdata_i[IRQ_W_L-1:0];
    end
  end

  // status mirrors the sticky flags, so both share one clear
  logic [IRQ_W_L-1:0] irq_stat;
  assign irq_stat = {ctrl_q[tmr2_pkg::BIT_EXF], ctrl_q[tmr2_pkg::BIT_OVF]};
  assign irq_o = |(irq_stat & irq_en_q);

  // read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        tmr2_pkg::ADDR_CONTROL:     rdata_q <= ctrl_q;
        tmr2_pkg::ADDR_COUNT_LOW:   rdata_q <= count_q[7:0];
        tmr2_pkg::ADDR_COUNT_HIGH:  rdata_q <= count_q[15:8];
        tmr2_pkg::ADDR_RELOAD_LOW:  rdata_q <= cap_q[7:0];
        tmr2_pkg::ADDR_RELOAD_HIGH: rdata_q <= cap_q[15:8];
        tmr2_pkg::ADDR_IRQ_STATUS:  rdata_q <= {6'h00, irq_stat};
        tmr2_pkg::ADDR_IRQ_ENABLE:  rdata_q <= {6'h00, irq_en_q};
        default:                    rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign reg_rdata_o = rdata_q;

  // checks
  chk_reload_on_roll: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (mode == tmr2_pkg::TMR2_MODE_RELOAD && rollover && !wr_cl && !wr_ch)
      |=> count_q == $past(cap_q) && ctrl_q[tmr2_pkg::BIT_OVF])
    else $error("reload rollover did not reload");
  chk_trig_reload: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (mode == tmr2_pkg::TMR2_MODE_RELOAD && trig_evt && !wr_cl && !wr_ch)
      |=> count_q == $past(cap_q))
    else $error("trigger did not reload");
  chk_baud_mode: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (run && baud) |-> mode == tmr2_pkg::TMR2_MODE_BAUD)
    else $error("baud mode not selected");
  chk_ovf_no_baud: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (baud && !ctrl_q[tmr2_pkg::BIT_OVF] && !wr_ctrl) |=> !ctrl_q[tmr2_pkg::BIT_OVF])
    else $error("overflow flag set in baud mode");
  chk_exf_set: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    trig_evt |=> ctrl_q[tmr2_pkg::BIT_EXF])
    else $error("external flag not set");
  chk_irq_exf: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (ctrl_q[tmr2_pkg::BIT_EXF] && irq_en_q[tmr2_pkg::IRQ_EXF]) |-> irq_o)
    else $error("external flag did not interrupt");
  chk_rx_route: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (!ctrl_q[tmr2_pkg::BIT_RCLK] && other_timer_ovf_i) |=> rx_baud_tick_o)
    else $error("rx clock not from other timer");
  chk_tx_route: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (ctrl_q[tmr2_pkg::BIT_TX_CLOCK_SELECT] && run && rollover) |=> tx_baud_tick_o)
    else $error("tx clock missed overflow");
  chk_trig_ignored: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (!exen || baud) |-> !trig_evt)
    else $error("trigger event while disabled");
  chk_stopped_hold: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (!run && !reg_wr_i && !trig_evt) |=> $stable(count_q))
    else $error("count moved while stopped");
  chk_capture_copy: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    capture |=> cap_q == $past(count_q))
    else $error("capture value wrong");
  cov_reload: cover property (@(posedge clk_sys_i) mode == tmr2_pkg::TMR2_MODE_RELOAD && rollover);
  cov_capture: cover property (@(posedge clk_sys_i) capture);
  cov_baud: cover property (@(posedge clk_sys_i) tx_baud_tick_o && ctrl_q[tmr2_pkg::BIT_TX_CLOCK_SELECT]);
  cov_trig_reload: cover property (@(posedge clk_sys_i)
    mode == tmr2_pkg::TMR2_MODE_RELOAD && trig_evt);
endmodule : tmr2_top
`default_nettype wire

// ==== shared/tmr2_edge_if.sv ====
// interface: synchronised pin falling-edge events from the edge detector
`default_nettype none
interface tmr2_edge_if;
  logic trig_fall; // falling edge on trigger pin
  logic cnt_fall;  // falling edge on count pin
  modport det (output trig_fall, output cnt_fall);
  modport use_ (input trig_fall, input cnt_fall);
endinterface : tmr2_edge_if
`default_nettype wire

// ==== shared/tmr2_pkg.sv ====
// package: register map, control bit positions and timing constants of timer2
`default_nettype none
package tmr2_pkg;
  // register offsets on the plain register port (word index)
  localparam logic [3:0] ADDR_CONTROL    = 4'h0;
  localparam logic [3:0] ADDR_COUNT_LOW  = 4'h1;
  localparam logic [3:0] ADDR_COUNT_HIGH = 4'h2;
  localparam logic [3:0] ADDR_RELOAD_LOW = 4'h3;
  localparam logic [3:0] ADDR_RELOAD_HIGH= 4'h4;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h5;
  localparam logic [3:0] ADDR_IRQ_CLEAR  = 4'h6;
  localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h7;
  // control register bit positions
  localparam int BIT_OVF    = 7;
  localparam int BIT_EXF    = 6;
  localparam int BIT_RCLK   = 5;
  localparam int BIT_TX_CLOCK_SELECT   = 4;
  localparam int BIT_EXEN   = 3;
  localparam int BIT_RUN    = 2;
  localparam int BIT_SRC    = 1;
  localparam int BIT_CAPSEL = 0;
  // interrupt status bit positions
  localparam int IRQ_OVF = 0;
  localparam int IRQ_EXF = 1;
  localparam int IRQ_W   = 2;
  // reset values
  localparam logic [7:0]  CONTROL_RST = 8'h00;
  localparam logic [15:0] COUNT_RST   = 16'h0000;
  localparam logic [15:0] RELOAD_RST  = 16'h0000;
  // internal tick: one tick per twelve oscillator periods
  localparam int OSC_DIV = 12;
  // operating mode
  typedef enum logic [1:0] {
    TMR2_MODE_OFF,
    TMR2_MODE_RELOAD,
    TMR2_MODE_CAPTURE,
    TMR2_MODE_BAUD
  } tmr2_mode_t;
endpackage : tmr2_pkg
`default_nettype wire
